/* hw/basca_pkg.sv */
package basca_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int DW = 8;   // data byte
  localparam int AW = 16;  // memory address
  localparam int RW = 3;   // general register index

  // ****************************************************************
  // register file layout and fixed addresses
  // ****************************************************************
  localparam logic [RW-1:0] REG_ACC  = 3'h1;  // accumulator
  localparam logic [RW-1:0] REG_E    = 3'h4;  // pointer_pair_two, low byte
  localparam logic [RW-1:0] REG_D    = 3'h5;  // pointer_pair_two, high byte
  localparam logic [RW-1:0] REG_L    = 3'h6;  // pointer_pair_three, low byte
  localparam logic [RW-1:0] REG_H    = 3'h7;  // pointer_pair_three, high byte
  localparam int            NUM_REGS = 8;

  localparam logic [DW-1:0] PAGE_HI    = 8'hFE;     // upper byte, paged indirect
  localparam logic [AW-1:0] SADDR_BASE = 16'hFE20;  // short direct window FE20H..FF1FH

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [DW-1:0] REG_RESET  = 8'h00;
  localparam logic [AW-1:0] ADDR_RESET = 16'h0000;
  localparam logic          FLAG_RESET = 1'b0;

  // ****************************************************************
  // operations and operand forms
  // ****************************************************************
  typedef enum logic [1:0] {
    OP_ADD,                  // sum, carry in ignored
    OP_SUM_WITH_CARRY_IN,    // sum_with_carry_in_op
    OP_SUB                   // difference, carry in ignored
  } basca_op_t;

  typedef enum logic [3:0] {
    F_IMM_ACC,    // A    <- A  op #byte
    F_IMM_SADDR,  // mem  <- mem op #byte, short direct
    F_IMM_SFR,    // sfr  <- sfr op #byte
    F_REG_REG,    // r    <- r  op r'
    F_ACC_SADDR,  // A    <- A  op short direct byte
    F_ACC_SFR,    // A    <- A  op sfr
    F_ACC_PAGED,  // A    <- A  op (FE00H + page_offset_register)
    F_ACC_PAIR3,  // A    <- A  op (pointer_pair_three)
    F_ACC_PAIR2,  // A    <- A  op (pointer_pair_two)
    F_ACC_INDEX   // A    <- A  op (word + index_register_operand)
  } basca_form_t;

  // alu answer: carry, half carry, result
  typedef struct packed {
    logic          cy;
    logic          ac;
    logic [DW-1:0] res;
  } basca_alu_t;

endpackage

/* hw/basca_rf_if.sv */
`timescale 1ns/10ps
interface basca_rf_if;
  import basca_pkg::*;
  logic [RW-1:0] raddr_a;
  logic [RW-1:0] raddr_b;
  logic [RW-1:0] raddr_c;
  logic [DW-1:0] rdata_a;
  logic [DW-1:0] rdata_b;
  logic [DW-1:0] rdata_c;
  logic          we;
  logic [RW-1:0] waddr;
  logic [DW-1:0] wdata;

  modport ctrl  (output raddr_a, raddr_b, raddr_c, we, waddr, wdata,
                 input  rdata_a, rdata_b, rdata_c);
  modport store (input  raddr_a, raddr_b, raddr_c, we, waddr, wdata,
                 output rdata_a, rdata_b, rdata_c);
endinterface

/* hw/basca_regfile.sv */
`timescale 1ns/10ps
module basca_regfile (
  // clock and reset
  input  wire logic  i_clk_sys,
  input  wire logic  i_resetn,
  // register access
  basca_rf_if.store  rf
);
  import basca_pkg::*;

  logic [DW-1:0] mem [NUM_REGS];

  // ****************************************************************
  // storage, one write port
  // ****************************************************************
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        mem[i] <= REG_RESET;
      end
    end else if (rf.we) begin
      mem[rf.waddr] <= rf.wdata;
    end
  end

  // ****************************************************************
  // registered read ports; a write shows one cycle later
  // ****************************************************************
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rf.rdata_a <= REG_RESET;
      rf.rdata_b <= REG_RESET;
      rf.rdata_c <= REG_RESET;
    end else begin
      rf.rdata_a <= mem[rf.raddr_a];
      rf.rdata_b <= mem[rf.raddr_b];
      rf.rdata_c <= mem[rf.raddr_c];
    end
  end

endmodule // basca_regfile

/* hw/basca_top.sv */
// How it works
// - indexed address is 16-bit base plus register
// - addition sets carry on overflow, else clears
// - immediate add-with-carry into accumulator
// - short direct add-with-carry written back there
// - sfr add-with-carry written back to sfr
// - register pair add-with-carry into first register
// - paged address is FE00H plus register
// - pointer pair three operand added with carry
// - pointer pair two operand added with carry
// - sfr operand added with carry into accumulator
// - subtraction sets carry on borrow, else clears
// - short direct subtract ignores carry, writes back
// - register subtract stores into first register
// - paged subtract reads page FEH byte
`timescale 1ns/10ps
module basca_top
  import basca_pkg::*;
(
  // clock and reset
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_resetn,
  // command
  input  wire logic                     i_cmd_valid,
  output logic                          o_cmd_ready,
  input  wire basca_pkg::basca_op_t     i_cmd_op,
  input  wire basca_pkg::basca_form_t   i_cmd_form,
  input  wire logic [basca_pkg::RW-1:0] i_cmd_dst,
  input  wire logic [basca_pkg::RW-1:0] i_cmd_src,
  input  wire logic [basca_pkg::DW-1:0] i_cmd_imm,
  input  wire logic [basca_pkg::DW-1:0] i_cmd_short,
  input  wire logic [basca_pkg::AW-1:0] i_cmd_word,
  output logic                          o_done,
  // result and flags
  output logic [basca_pkg::DW-1:0]      o_result,
  output logic                          o_carry_flag,
  output logic                          o_zero_flag,
  output logic                          o_half_carry_flag,
  input  wire logic                     i_carry_load,
  input  wire logic                     i_carry_value,
  // general register access while idle
  input  wire logic                     i_reg_wr,
  input  wire logic [basca_pkg::RW-1:0] i_reg_addr,
  input  wire logic [basca_pkg::DW-1:0] i_reg_wdata,
  output logic [basca_pkg::DW-1:0]      o_reg_rdata,
  // data bus to memory and special function registers
  output logic                          o_bus_req,
  output logic                          o_bus_we,
  output logic                          o_bus_sfr,
  output logic [basca_pkg::AW-1:0]      o_bus_addr,
  output logic [basca_pkg::DW-1:0]      o_bus_wdata,
  input  wire logic                     i_bus_ack,
  input  wire logic [basca_pkg::DW-1:0] i_bus_rdata
);
  import basca_pkg::*;

  // ****************************************************************
  // arithmetic
  // ****************************************************************
  // one function for every form keeps the flag rules in one place
  function automatic basca_alu_t alu(input basca_op_t op, input logic [DW-1:0] a,
                                     input logic [DW-1:0] b, input logic cin);
    basca_alu_t    r;
    logic [DW:0]   full;
    logic [4:0]    low;
    logic          c;
    r    = '{cy: 1'b0, ac: 1'b0, res: '0};
    c    = (op == OP_SUM_WITH_CARRY_IN) ? cin : 1'b0;
    if (op == OP_SUB) begin
      full = {1'b0, a} - {1'b0, b};
      low  = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    end else begin
      full = {1'b0, a} + {1'b0, b} + {{DW{1'b0}}, c};
      low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
    end
    r.res = full[DW-1:0];
    r.cy  = full[DW];
    r.ac  = low[4];
    return r;
  endfunction

  // true for forms whose destination sits on the data bus
  function automatic logic dst_on_bus(input basca_form_t f);
    return (f == F_IMM_SADDR) || (f == F_IMM_SFR);
  endfunction

  // forms whose operands all come from the register file and the command
  function automatic logic regs_only(input basca_form_t f);
    return (f == F_IMM_ACC) || (f == F_REG_REG);
  endfunction

  // register that is first operand and destination; the accumulator by default
  function automatic logic [RW-1:0] reg_target(input basca_form_t f,
                                               input logic [RW-1:0] d);
    return (f == F_REG_REG) ? d : REG_ACC;
  endfunction

  // forms that address special function register space
  function automatic logic sfr_space(input basca_form_t f);
    return (f == F_IMM_SFR) || (f == F_ACC_SFR);
  endfunction

  // ****************************************************************
  // state and storage
  // ****************************************************************
  typedef enum logic [2:0] {S_IDLE, S_READ, S_ADDR, S_MEM, S_EXEC, S_WB} basca_state_t;

  basca_state_t  state;
  basca_state_t  next_state;
  basca_op_t     op;
  basca_form_t   form;
  logic [RW-1:0] dst;
  logic [RW-1:0] src;
  logic [DW-1:0] imm;
  logic [DW-1:0] short_ofs;
  logic [AW-1:0] word;
  logic [DW-1:0] opa;
  logic [DW-1:0] opb;
  logic          mem_is_sfr;
  basca_alu_t    alu_out;
  logic          retire_reg;

  // register file; read data arrive one cycle after the address
  basca_rf_if rf ();

  basca_regfile u_regfile (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .rf        (rf.store)
  );

  // the alu sees the carry flag as it stands before the instruction retires
  assign alu_out     = alu(op, opa, opb, o_carry_flag);
  assign retire_reg  = (state == S_EXEC) && !dst_on_bus(form);

  // handshake and bus strobes decode the state directly
  assign o_cmd_ready = (state == S_IDLE);
  assign o_bus_req   = (state == S_MEM) || (state == S_WB);
  assign o_bus_we    = (state == S_WB);

  // data outputs all come from flip-flops
  assign o_bus_sfr   = mem_is_sfr;
  assign o_bus_wdata = o_result;
  assign o_reg_rdata = rf.rdata_c;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // bus steps wait for the acknowledge, idle waits for a command, every other step takes one cycle
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: if (i_cmd_valid) next_state = S_READ;
      S_READ: next_state = S_ADDR;
      S_ADDR: next_state = regs_only(form) ? S_EXEC : S_MEM;
      S_MEM:  if (i_bus_ack) next_state = S_EXEC;
      S_EXEC: next_state = dst_on_bus(form) ? S_WB : S_IDLE;
      S_WB:   if (i_bus_ack) next_state = S_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // done pulses as the last step retires
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_done <= 1'b0;
    end else begin
      o_done <= retire_reg || ((state == S_WB) && i_bus_ack);
    end
  end

  // ****************************************************************
  // command capture; held for the whole instruction
  // ****************************************************************
  // the command inputs are free to move once the take edge has passed
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      op        <= OP_ADD;
      form      <= F_IMM_ACC;
      dst       <= '0;
      src       <= '0;
      imm       <= REG_RESET;
      short_ofs <= REG_RESET;
      word      <= ADDR_RESET;
    end else if (o_cmd_ready && i_cmd_valid) begin
      op        <= i_cmd_op;
      form      <= i_cmd_form;
      dst       <= i_cmd_dst;
      src       <= i_cmd_src;
      imm       <= i_cmd_imm;
      short_ofs <= i_cmd_short;
      word      <= i_cmd_word;
    end
  end

  // ****************************************************************
  // register file ports
  // ****************************************************************
  // port a: destination, port b: source or low pointer, port c: high pointer
  always_comb begin
    rf.raddr_a = reg_target(form, dst);
    rf.raddr_b = src;
    rf.raddr_c = i_reg_addr;
    unique case (form)
      F_ACC_PAIR3: begin
        rf.raddr_b = REG_L;
        rf.raddr_c = REG_H;
      end
      F_ACC_PAIR2: begin
        rf.raddr_b = REG_E;
        rf.raddr_c = REG_D;
      end
      default: ;
    endcase
    // outside the read step port c serves the register access port
    if (state != S_READ) begin
      rf.raddr_c = i_reg_addr;
    end
  end

  // results go back to a register unless the destination is on the bus
  always_comb begin
    rf.we    = 1'b0;
    rf.waddr = i_reg_addr;
    rf.wdata = i_reg_wdata;
    if (retire_reg) begin
      rf.we    = 1'b1;
      rf.waddr = reg_target(form, dst);
      rf.wdata = alu_out.res;
    end else if (state == S_IDLE) begin
      rf.we    = i_reg_wr;                                      // outside writes only while idle
    end
  end

  // ****************************************************************
  // operands and effective address
  // ****************************************************************
  // the address is registered, so the bus never sees it settle mid-cycle
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      opa        <= REG_RESET;
      opb        <= REG_RESET;
      o_bus_addr <= ADDR_RESET;
      mem_is_sfr <= 1'b0;
    end else if (state == S_ADDR) begin
      opa        <= rf.rdata_a;
      opb        <= (form == F_REG_REG) ? rf.rdata_b : imm;
      mem_is_sfr <= sfr_space(form);
      unique case (form)
        F_IMM_SADDR, F_ACC_SADDR:
          o_bus_addr <= SADDR_BASE + {8'h00, short_ofs};
        F_IMM_SFR, F_ACC_SFR:
          o_bus_addr <= {8'h00, short_ofs};
        F_ACC_PAGED:
          o_bus_addr <= {PAGE_HI, rf.rdata_b};
        F_ACC_PAIR3, F_ACC_PAIR2:
          o_bus_addr <= {rf.rdata_c, rf.rdata_b};
        F_ACC_INDEX:
          o_bus_addr <= word + {8'h00, rf.rdata_b};
        default:
          o_bus_addr <= o_bus_addr;
      endcase
    end else if (state == S_MEM && i_bus_ack) begin
      // the fetched byte is the destination for write-back forms
      if (dst_on_bus(form)) begin
        opa <= i_bus_rdata;
      end else begin
        opb <= i_bus_rdata;
      end
    end
  end

  // ****************************************************************
  // result and flags
  // ****************************************************************
  // result byte stands until the next instruction executes
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_result <= REG_RESET;
    end else if (state == S_EXEC) begin
      o_result <= alu_out.res;                                   // also the write-back byte
    end
  end

  // an instruction's own flag update wins over an outside carry load
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_carry_flag      <= FLAG_RESET;
      o_zero_flag       <= FLAG_RESET;
      o_half_carry_flag <= FLAG_RESET;
    end else if (state == S_EXEC) begin
      o_carry_flag      <= alu_out.cy;
      o_zero_flag       <= (alu_out.res == '0);
      o_half_carry_flag <= alu_out.ac;
    end else if (i_carry_load) begin
      o_carry_flag      <= i_carry_value;
    end
  end

endmodule // basca_top

/* verif/basca_properties.sv */
`timescale 1ns/10ps
module basca_properties
  import basca_pkg::*;
(
  // clock and reset
  input wire logic                     i_clk_sys,
  input wire logic                     i_resetn,
  // command side
  input wire logic                     i_cmd_valid,
  input wire logic                     o_cmd_ready,
  input wire basca_pkg::basca_op_t     i_cmd_op,
  input wire basca_pkg::basca_form_t   i_cmd_form,
  input wire logic [basca_pkg::DW-1:0] i_cmd_imm,
  input wire logic [basca_pkg::DW-1:0] i_cmd_short,
  input wire logic                     o_done,
  input wire logic [basca_pkg::DW-1:0] o_result,
  input wire logic                     o_carry_flag,
  input wire logic                     o_zero_flag,
  // data bus
  input wire logic                     o_bus_req,
  input wire logic                     o_bus_we,
  input wire logic                     o_bus_sfr,
  input wire logic [basca_pkg::AW-1:0] o_bus_addr,
  input wire logic [basca_pkg::DW-1:0] o_bus_wdata,
  input wire logic                     i_bus_ack,
  input wire logic [basca_pkg::DW-1:0] i_bus_rdata
);
  // ****************************************************************
  // operand capture
  // ****************************************************************
  basca_op_t     op_q;
  basca_form_t   form_q;
  logic [DW-1:0] imm_q;
  logic [DW-1:0] short_q;
  logic [DW-1:0] rd_q;
  logic [AW-1:0] rda_q;
  logic          cy_q;
  logic [DW:0]   exp_sum;
  wire           take   = i_cmd_valid && o_cmd_ready;
  wire           mem_wb = form_q == F_IMM_SADDR || form_q == F_IMM_SFR;

  // held from the take, since the command inputs may move while busy
  always_ff @(posedge i_clk_sys) begin
    if (take) begin
      op_q    <= i_cmd_op;
      form_q  <= i_cmd_form;
      imm_q   <= i_cmd_imm;
      short_q <= i_cmd_short;
      cy_q    <= o_carry_flag;
    end
  end

  // byte and address of the read half of a read-modify-write
  always_ff @(posedge i_clk_sys) begin
    if (o_bus_req && !o_bus_we && i_bus_ack) begin
      rd_q  <= i_bus_rdata;
      rda_q <= o_bus_addr;
    end
  end

  // reference sum for the write-back forms, bit 8 is carry or borrow
  always_comb begin
    if (op_q == OP_SUB)
      exp_sum = {1'b0, rd_q} - {1'b0, imm_q};
    else
      exp_sum = {1'b0, rd_q} + {1'b0, imm_q} + {8'h00, op_q == OP_SUM_WITH_CARRY_IN && cy_q};
  end

  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  sequence s_quick_take;
    take && (i_cmd_form == F_IMM_ACC || i_cmd_form == F_REG_REG);
  endsequence
  sequence s_wb_read;
    o_bus_req && !o_bus_we && i_bus_ack && mem_wb;
  endsequence

  property p_quick_done;
    s_quick_take |=> !o_done [*3] ##1 o_done;
  endproperty
  a_quick_done: assert property (p_quick_done) else $error("short form done late");

  property p_busy;
    take |=> !o_cmd_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");

  property p_paged_page;
    form_q == F_ACC_PAGED && o_bus_req |-> o_bus_addr[15:8] == PAGE_HI && !o_bus_sfr;
  endproperty
  a_paged_page: assert property (p_paged_page) else $error("paged upper byte wrong");

  property p_short_addr;
    (form_q == F_IMM_SADDR || form_q == F_ACC_SADDR) && o_bus_req
      |-> o_bus_addr == SADDR_BASE + {8'h00, short_q} && !o_bus_sfr;
  endproperty
  a_short_addr: assert property (p_short_addr) else $error("short address wrong");

  property p_sfr_space;
    (form_q == F_IMM_SFR || form_q == F_ACC_SFR) && o_bus_req
      |-> o_bus_sfr && o_bus_addr[7:0] == short_q;
  endproperty
  a_sfr_space: assert property (p_sfr_space) else $error("sfr access wrong");

  property p_wb_data;
    o_bus_req && o_bus_we |-> o_bus_addr == rda_q && o_bus_wdata == exp_sum[7:0];
  endproperty
  a_wb_data: assert property (p_wb_data) else $error("write-back wrong");

  property p_wb_follows;
    s_wb_read |=> !o_bus_req ##1 (o_bus_req && o_bus_we);
  endproperty
  a_wb_follows: assert property (p_wb_follows) else $error("write-back missing");

  property p_mem_flags;
    o_done && mem_wb |-> o_result == exp_sum[7:0] && o_carry_flag == exp_sum[8];
  endproperty
  a_mem_flags: assert property (p_mem_flags) else $error("carry wrong");

  property p_zero;
    o_done |-> o_zero_flag == (o_result == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_bus_hold;
    o_bus_req && !i_bus_ack |=> o_bus_req && $stable(o_bus_addr) && $stable(o_bus_we);
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("bus request dropped");
endmodule // basca_properties

bind basca_top basca_properties u_basca_properties (
  .i_clk_sys, .i_resetn, .i_cmd_valid, .o_cmd_ready, .i_cmd_op, .i_cmd_form, .i_cmd_imm,
  .i_cmd_short, .o_done, .o_result, .o_carry_flag, .o_zero_flag, .o_bus_req, .o_bus_we,
  .o_bus_sfr, .o_bus_addr, .o_bus_wdata, .i_bus_ack, .i_bus_rdata
);

/* verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import basca_pkg::*;
  // ****************************************************************
  // design hookup and model state
  // ****************************************************************
  logic          i_clk_sys, i_resetn, i_cmd_valid, i_carry_load, i_carry_value, i_reg_wr;
  logic          i_bus_ack, o_cmd_ready, o_done, o_carry_flag, o_zero_flag;
  logic          o_half_carry_flag, o_bus_req, o_bus_we, o_bus_sfr;
  basca_op_t     i_cmd_op;
  basca_form_t   i_cmd_form;
  logic [RW-1:0] i_cmd_dst, i_cmd_src, i_reg_addr;
  logic [DW-1:0] i_cmd_imm, i_cmd_short, i_reg_wdata, i_bus_rdata;
  logic [DW-1:0] o_result, o_reg_rdata, o_bus_wdata;
  logic [AW-1:0] i_cmd_word, o_bus_addr;
  logic [DW-1:0] regs [NUM_REGS];
  logic [DW-1:0] edges [4] = '{8'h00, 8'hFF, 8'h01, 8'h0F};
  logic          cy_m;
  integer        seed = 12709;
  int            num_errors = 0;
  int            n_tests = 0;

  basca_top u_basca_top (
    .i_clk_sys, .i_resetn, .i_cmd_valid, .o_cmd_ready, .i_cmd_op, .i_cmd_form, .i_cmd_dst,
    .i_cmd_src, .i_cmd_imm, .i_cmd_short, .i_cmd_word, .o_done, .o_result, .o_carry_flag,
    .o_zero_flag, .o_half_carry_flag, .i_carry_load, .i_carry_value, .i_reg_wr, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .o_bus_req, .o_bus_we, .o_bus_sfr, .o_bus_addr,
    .o_bus_wdata, .i_bus_ack, .i_bus_rdata
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // boundary bytes half the time, since carries hide at 00 and FF
  function automatic logic [DW-1:0] pick();
    return ($random(seed) % 2 == 0) ? edges[2'($random(seed))] : 8'($random(seed));
  endfunction

  // returns carry, half carry, result
  function automatic logic [9:0] alu(basca_op_t op, logic [7:0] a, logic [7:0] b, logic c);
    logic [8:0] s;
    logic [4:0] h;
    logic       ci;
    ci = (op == OP_SUM_WITH_CARRY_IN) ? c : 1'b0;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    if (op == OP_SUB) begin
      s = {1'b0, a} - {1'b0, b};
      h = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    end
    return {s[8], h[4], s[7:0]};
  endfunction

  // sfr flag above the expected bus address
  function automatic logic [AW:0] bus_addr(basca_form_t f, logic [2:0] s, logic [7:0] sh,
                                           logic [15:0] w);
    case (f)
      F_IMM_SADDR, F_ACC_SADDR: return {1'b0, SADDR_BASE + {8'h00, sh}};
      F_IMM_SFR, F_ACC_SFR:     return {9'h100, sh};
      F_ACC_PAGED:              return {1'b0, PAGE_HI, regs[s]};
      F_ACC_PAIR3:              return {1'b0, regs[REG_H], regs[REG_L]};
      F_ACC_PAIR2:              return {1'b0, regs[REG_D], regs[REG_E]};
      default:                  return {1'b0, w + {8'h00, regs[s]}};
    endcase
  endfunction

  task automatic wr_reg(input logic [RW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
    regs[a] = d;
  endtask

  task automatic rd_reg(input logic [RW-1:0] a, output logic [DW-1:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    d = o_reg_rdata;
  endtask

  task automatic set_carry(input logic v);
    @(posedge i_clk_sys);
    i_carry_load <= 1'b1;
    i_carry_value <= v;
    @(posedge i_clk_sys);
    i_carry_load <= 1'b0;
    cy_m = v;
  endtask

  // one instruction, the bench answering the bus with random stalls
  task automatic run(input basca_op_t op, input basca_form_t f);
    logic [RW-1:0] dst, src, rsel;
    logic [DW-1:0] a, b, imm, sh, rd, got;
    logic [AW-1:0] w;
    logic [9:0]    e;
    dst = 3'($random(seed));
    src = 3'($random(seed));
    imm = pick();
    sh = pick();
    rd = pick();
    w = {pick(), pick()};
    a = (f == F_REG_REG) ? regs[dst] : (f == F_IMM_SADDR || f == F_IMM_SFR) ? rd : regs[REG_ACC];
    b = (f == F_REG_REG) ? regs[src] : (f <= F_IMM_SFR) ? imm : rd;
    e = alu(op, a, b, cy_m);
    @(posedge i_clk_sys);
    i_cmd_valid <= 1'b1;
    i_cmd_op <= op;
    i_cmd_form <= f;
    i_cmd_dst <= dst;
    i_cmd_src <= src;
    i_cmd_imm <= imm;
    i_cmd_short <= sh;
    i_cmd_word <= w;
    @(posedge i_clk_sys);
    i_cmd_valid <= 1'b0;
    i_cmd_imm <= ~imm;
    for (int n = 0; n < 40; n++) begin
      @(negedge i_clk_sys);
      if (o_done === 1'b1) break;
      if (o_bus_req === 1'b1 && $random(seed) % 3 != 0) begin
        check({o_bus_sfr, o_bus_sfr ? {8'h00, o_bus_addr[7:0]} : o_bus_addr},
              bus_addr(f, src, sh, w));
        if (o_bus_we === 1'b1) check({9'h000, o_bus_wdata}, {9'h000, e[7:0]});
        @(posedge i_clk_sys);
        i_bus_ack <= 1'b1;
        i_bus_rdata <= rd;
        @(posedge i_clk_sys);
        i_bus_ack <= 1'b0;
        i_bus_rdata <= ~rd;
      end
    end
    check({16'h0000, o_done}, 17'h00001);
    check({7'h00, o_carry_flag, o_half_carry_flag, o_result}, {7'h00, e});
    check({16'h0000, o_zero_flag}, {16'h0000, e[7:0] == 8'h00});
    cy_m = e[9];
    if (f != F_IMM_SADDR && f != F_IMM_SFR) begin
      rsel = (f == F_REG_REG) ? dst : REG_ACC;
      regs[rsel] = e[7:0];
      rd_reg(rsel, got);
      check({9'h000, got}, {9'h000, e[7:0]});
    end
  endtask

  // ****************************************************************
  // clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  // the run needs about 3500 cycles, so this leaves a wide margin
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    num_errors++;
    results();
  end

  initial begin
    logic [DW-1:0] got;
    i_resetn = 1'b0;
    {i_cmd_valid, i_carry_load, i_carry_value, i_reg_wr, i_bus_ack} = '0;
    {i_cmd_dst, i_cmd_src, i_reg_addr, i_cmd_imm, i_cmd_short, i_reg_wdata} = '0;
    {i_bus_rdata, i_cmd_word} = '0;
    i_cmd_op = OP_ADD;
    i_cmd_form = F_IMM_ACC;
    repeat (4) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    @(negedge i_clk_sys);
    check({3'h0, o_cmd_ready, o_done, o_bus_req, o_carry_flag, o_zero_flag, o_half_carry_flag,
           o_result}, {3'h0, 6'b100000, REG_RESET});
    rd_reg(REG_ACC, got);
    check({9'h000, got}, {9'h000, REG_RESET});
    // first 30 pass every operation through every form, then random
    for (int i = 0; i < 230; i++) begin
      if (i % 4 == 0)
        for (int r = 0; r < NUM_REGS; r++) wr_reg(3'(r), pick());
      set_carry(1'($random(seed)));
      if (i < 30) run(basca_op_t'(i / 10), basca_form_t'(i % 10));
      else run(basca_op_t'({$random(seed)} % 3), basca_form_t'({$random(seed)} % 10));
      if (i == 29 || i == 229) $display("test phase ends at %0d, mismatches %0d", i, num_errors);
    end
    results();
  end
endmodule // testbench
